// *** verilog/pic_pkg.sv ***
`default_nettype none
package pic_pkg;
   localparam int NUM_SRC      = 46;
   localparam int NUM_FIXED    = 6;
   localparam int NUM_FIELDS   = 40;
   localparam int NUM_PRI_REGS = 5;
   localparam int DEBUG_FIELDS = 5;
   localparam int NUM_LEVELS   = 4;
   localparam int DATA_W       = 16;
   localparam int ADDR_W       = 5;
   localparam int VEC_W        = 7;
   localparam int VADDR_W      = 32;
   localparam int PAD_W        = VADDR_W - DATA_W - VEC_W;

   localparam logic [ADDR_W-1:0] OFS_PRI0   = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_VBA    = 5'h05;
   localparam logic [ADDR_W-1:0] OFS_FM0    = 5'h06;
   localparam logic [ADDR_W-1:0] OFS_FVL0   = 5'h07;
   localparam logic [ADDR_W-1:0] OFS_FVH0   = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_FM1    = 5'h09;
   localparam logic [ADDR_W-1:0] OFS_FVL1   = 5'h0a;
   localparam logic [ADDR_W-1:0] OFS_FVH1   = 5'h0b;
   localparam logic [ADDR_W-1:0] OFS_PEND0  = 5'h0c;
   localparam logic [ADDR_W-1:0] OFS_PEND1  = 5'h0d;
   localparam logic [ADDR_W-1:0] OFS_PEND2  = 5'h0e;
   localparam logic [ADDR_W-1:0] OFS_CTRL   = 5'h12;

   localparam logic [DATA_W-1:0] REG_RESET     = 16'h0000;
   localparam logic [DATA_W-1:0] PRI0_WMASK    = 16'hc3ff;
   localparam logic [DATA_W-1:0] PRI1_WMASK    = 16'hfcff;
   localparam logic [DATA_W-1:0] PRI2_WMASK    = 16'hf3ff;
   localparam logic [DATA_W-1:0] PRI_FULL_MASK = 16'hffff;

   localparam logic [1:0] FIXED_LEVEL = 2'h3;
   localparam logic [1:0] FAST_LEVEL  = 2'h2;
   localparam logic [1:0] BASE_NORMAL = 2'h0;
   localparam logic [1:0] BASE_DEBUG  = 2'h1;

   localparam int CTRL_DIS_BIT = 5;
   localparam int CTRL_VEC_LSB = 6;
   localparam int CTRL_LVL_LSB = 13;
   localparam int CTRL_REQ_BIT = 15;

   localparam logic [VADDR_W-1:0] BOOT_ADDR = 32'h0000_0000;

   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } pic_bus_req_t;

   typedef struct packed {
      logic               req;
      logic               fast;
      logic [1:0]         level;
      logic [VEC_W-1:0]   num;
      logic [VADDR_W-1:0] addr;
   } pic_vec_t;
endpackage
`default_nettype wire

// *** verilog/pic_ffs.sv ***
`timescale 1ns/10ps
`default_nettype none
// Finds the lowest-numbered active request.
module pic_ffs
   import pic_pkg::*;
#(
   parameter int N     = 46,
   parameter int IDX_W = 7
)
(
   input  wire logic [N-1:0]     i_req,    // Active requests
   output var  logic             o_found,  // Any request active
   output var  logic [IDX_W-1:0] o_idx     // Lowest active index
);
   always_comb
   begin
      o_found = 1'b0;
      o_idx   = '0;
      for (int i = N - 1; i >= 0; i--)
      begin
         if (i_req[i])
         begin
            o_found = 1'b1;
            o_idx   = i[IDX_W-1:0];
         end
      end
   end
endmodule
`default_nettype wire

// *** verilog/pic_field_dec.sv ***
`timescale 1ns/10ps
`default_nettype none
// Turns a two-bit priority field into an enable and a level.
module pic_field_dec
   import pic_pkg::*;
#(
   parameter logic [1:0] LEVEL_BASE = 2'h0
)
(
   input  wire logic [1:0] i_field,  // Priority field
   output var  logic       o_en,     // Source enabled
   output var  logic [1:0] o_level   // Decoded level
);
   always_comb
   begin
      o_en    = |i_field;
      o_level = 2'(i_field - 2'h1 + LEVEL_BASE);
   end
endmodule
`default_nettype wire

// *** verilog/pic_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module pic_top
   import pic_pkg::*;
(
   input  wire logic               i_sys_clk,      // System clock
   input  wire logic               i_rst,          // Asynchronous reset, active high
   input  wire pic_bus_req_t       i_bus,          // Register bus request
   output var  logic [DATA_W-1:0]  o_rdata,        // Register read data
   output var  logic               o_rd_valid,     // Read data valid pulse
   input  wire logic [NUM_SRC-1:0] i_irq,          // Interrupt requests, high active
   input  wire logic [1:0]         i_sr_mask,      // Core status mask bits
   input  wire logic               i_low_power,    // Core in wait or stop mode
   input  wire logic               i_boot_ack,     // Core took the boot address
   output pic_vec_t                o_vec,          // Request, level, vector and address
   output logic                    o_wake,         // Wake request to system integration
   output logic                    o_boot_en,      // Boot address is being driven
   output logic [VADDR_W-1:0]      o_boot_addr     // Initial fetch address
);
   logic [DATA_W-1:0]  pri_q [NUM_PRI_REGS];
   logic [DATA_W-1:0]  vba_q;
   logic [DATA_W-1:0]  fm_q  [2];
   logic [DATA_W-1:0]  fvl_q [2];
   logic [DATA_W-1:0]  fvh_q [2];
   logic               dis_q;
   logic [NUM_SRC-1:0] src_en;
   logic [1:0]         src_lvl [NUM_SRC];
   logic [NUM_SRC-1:0] active;
   logic [NUM_SRC-1:0] lvl_req [NUM_LEVELS];
   logic [NUM_LEVELS-1:0] lvl_found;
   logic [VEC_W-1:0]   lvl_idx [NUM_LEVELS];
   logic [NUM_SRC-1:0] en_snap_q;
   pic_vec_t           vec_d;
   pic_vec_t           vec_q;
   logic [NUM_SRC-1:0] win_same;
   logic [1:0]         win_lvl;
   logic               win_any;
   logic [VEC_W-1:0]   win_num;
   logic               fast0;
   logic               fast1;
   logic [NUM_SRC-1:0] win_same_q;
   logic               wake_q;
   logic               boot_en_q;
   logic [VADDR_W-1:0] boot_addr_q;

   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_rst);

   function automatic logic [DATA_W-1:0] pri_wmask(input int idx);
      if (idx == 0)
         return PRI0_WMASK;
      else if (idx == 1)
         return PRI1_WMASK;
      else if (idx == 2)
         return PRI2_WMASK;
      else
         return PRI_FULL_MASK;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Register writes.
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         for (int i = 0; i < NUM_PRI_REGS; i++)
            pri_q[i] <= REG_RESET;
         vba_q <= REG_RESET;
         for (int s = 0; s < 2; s++)
         begin
            fm_q[s]  <= REG_RESET;
            fvl_q[s] <= REG_RESET;
            fvh_q[s] <= REG_RESET;
         end
         dis_q <= 1'b0;
      end
      else if (i_bus.wr)
      begin
         for (int i = 0; i < NUM_PRI_REGS; i++)
            if (i_bus.addr == OFS_PRI0 + ADDR_W'(i))
               pri_q[i] <= i_bus.wdata & pri_wmask(i);
         if (i_bus.addr == OFS_VBA)
            vba_q <= i_bus.wdata;
         else if (i_bus.addr == OFS_FM0)
            fm_q[0] <= i_bus.wdata;
         else if (i_bus.addr == OFS_FVL0)
            fvl_q[0] <= i_bus.wdata;
         else if (i_bus.addr == OFS_FVH0)
            fvh_q[0] <= i_bus.wdata;
         else if (i_bus.addr == OFS_FM1)
            fm_q[1] <= i_bus.wdata;
         else if (i_bus.addr == OFS_FVL1)
            fvl_q[1] <= i_bus.wdata;
         else if (i_bus.addr == OFS_FVH1)
            fvh_q[1] <= i_bus.wdata;
         else if (i_bus.addr == OFS_CTRL)
            dis_q <= i_bus.wdata[CTRL_DIS_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Register reads; unmapped offsets read as zero.
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_rdata    <= REG_RESET;
         o_rd_valid <= 1'b0;
      end
      else
      begin
         o_rd_valid <= i_bus.rd;
         if (i_bus.rd)
         begin
            if (i_bus.addr < OFS_VBA)
               o_rdata <= pri_q[i_bus.addr[2:0]];
            else if (i_bus.addr == OFS_VBA)
               o_rdata <= vba_q;
            else if (i_bus.addr == OFS_FM0)
               o_rdata <= fm_q[0];
            else if (i_bus.addr == OFS_FVL0)
               o_rdata <= fvl_q[0];
            else if (i_bus.addr == OFS_FVH0)
               o_rdata <= fvh_q[0];
            else if (i_bus.addr == OFS_FM1)
               o_rdata <= fm_q[1];
            else if (i_bus.addr == OFS_FVL1)
               o_rdata <= fvl_q[1];
            else if (i_bus.addr == OFS_FVH1)
               o_rdata <= fvh_q[1];
            else if (i_bus.addr == OFS_PEND0)
               o_rdata <= i_irq[15:0];
            else if (i_bus.addr == OFS_PEND1)
               o_rdata <= i_irq[31:16];
            else if (i_bus.addr == OFS_PEND2)
               o_rdata <= {2'h0, i_irq[NUM_SRC-1:32]};
            else if (i_bus.addr == OFS_CTRL)
               o_rdata <= {vec_q.req, vec_q.level, vec_q.num, dis_q, 5'h00};
            else
               o_rdata <= REG_RESET;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Per-source enable and level.
   generate
      for (genvar g = 0; g < NUM_SRC; g++)
      begin : g_src
         if (g < NUM_FIXED)
         begin : g_fixed
            assign src_en[g]  = 1'b1;
            assign src_lvl[g] = FIXED_LEVEL;
         end
         else
         begin : g_prog
            localparam int K = g - NUM_FIXED;
            localparam int R = K / 8;
            localparam int P = (K % 8) * 2;
            localparam logic [1:0] BASE = (R == 0 && (K % 8) < DEBUG_FIELDS) ? BASE_DEBUG : BASE_NORMAL;
            pic_field_dec #(
               .LEVEL_BASE (BASE)
            ) u_dec (
               .i_field    (pri_q[R][P+1:P]),
               .o_en       (src_en[g]),
               .o_level    (src_lvl[g])
            );
         end
      end
   endgenerate

   assign active = i_irq & src_en;

   generate
      for (genvar l = 0; l < NUM_LEVELS; l++)
      begin : g_lvl
         always_comb
         begin
            for (int i = 0; i < NUM_SRC; i++)
               lvl_req[l][i] = active[i] && (src_lvl[i] == 2'(l)) && (2'(l) >= i_sr_mask);
         end
         pic_ffs #(
            .N       (NUM_SRC),
            .IDX_W   (VEC_W)
         ) u_ffs (
            .i_req   (lvl_req[l]),
            .o_found (lvl_found[l]),
            .o_idx   (lvl_idx[l])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Level arbitration and vector forming.
   always_comb
   begin
      win_any  = 1'b0;
      win_lvl  = 2'h0;
      win_num  = '0;
      win_same = '0;
      for (int l = 0; l < NUM_LEVELS; l++)
      begin
         if (lvl_found[l])
         begin
            win_any  = 1'b1;
            win_lvl  = 2'(l);
            win_num  = lvl_idx[l];
            win_same = lvl_req[l];
         end
      end
      fast0 = (fm_q[0][VEC_W-1:0] == win_num) && (win_lvl == FAST_LEVEL);
      fast1 = (fm_q[1][VEC_W-1:0] == win_num) && (win_lvl == FAST_LEVEL);
      vec_d.req   = win_any && !dis_q;
      vec_d.fast  = vec_d.req && (fast0 || fast1);
      vec_d.level = win_lvl;
      vec_d.num   = win_num;
      if (vec_d.fast && fast0)
         vec_d.addr = {fvh_q[0], fvl_q[0]};
      else if (vec_d.fast)
         vec_d.addr = {fvh_q[1], fvl_q[1]};
      else
         vec_d.addr = {{PAD_W{1'b0}}, vba_q, win_num};
   end

   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         vec_q      <= '0;
         win_same_q <= '0;
      end
      else
      begin
         vec_q      <= vec_d;
         win_same_q <= win_same;
      end
   end

   assign o_vec = vec_q;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Wake-up; enables freeze while the core sleeps.
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         en_snap_q <= '0;
         wake_q    <= 1'b0;
      end
      else
      begin
         if (!i_low_power)
            en_snap_q <= src_en;
         wake_q <= i_low_power && |(i_irq & en_snap_q);
      end
   end

   assign o_wake = wake_q;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Boot address drive after reset.
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         boot_en_q   <= 1'b1;
         boot_addr_q <= BOOT_ADDR;
      end
      else
      begin
         boot_addr_q <= BOOT_ADDR;
         if (i_boot_ack)
            boot_en_q <= 1'b0;
      end
   end

   assign o_boot_en   = boot_en_q;
   assign o_boot_addr = boot_addr_q;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Checks.
   a_mask_gates_level: assert property (vec_q.req |-> vec_q.level >= $past(i_sr_mask))
      else $error("presented level is masked");
   a_lowest_source: assert property (vec_q.req |->
      (win_same_q & ((46'h1 << vec_q.num) - 46'h1)) == '0)
      else $error("lower source at same level was skipped");
   a_normal_address: assert property (vec_q.req && !vec_q.fast |->
      vec_q.addr == {{PAD_W{1'b0}}, $past(vba_q), vec_q.num})
      else $error("normal vector address wrong");
   a_fast_only_level2: assert property (vec_q.fast |-> vec_q.req && vec_q.level == FAST_LEVEL)
      else $error("fast vector outside level 2");
   a_fast_slot0_addr: assert property (vec_q.fast && $past(fm_q[0][VEC_W-1:0]) == vec_q.num |->
      vec_q.addr == {$past(fvh_q[0]), $past(fvl_q[0])})
      else $error("fast slot 0 address wrong");
   a_fast_detected: assert property (vec_q.req && vec_q.level == FAST_LEVEL &&
      $past(fm_q[1][VEC_W-1:0]) == vec_q.num |-> vec_q.fast)
      else $error("fast match not flagged");
   a_wake_pending: assert property (i_low_power && |(i_irq & en_snap_q) |=> o_wake)
      else $error("pending request gave no wake");
   a_wake_only_sleep: assert property (o_wake |-> $past(i_low_power))
      else $error("wake while awake");
   a_reserved_zero: assert property (pri_q[0][13:10] == 4'h0)
      else $error("reserved priority bits set");
   a_boot_holds: assert property (o_boot_en && !i_boot_ack |=> o_boot_en)
      else $error("boot drive dropped early");

   // Bus, boot, arbitration, fast vector address and wake checks.
   a_rd_valid_pulse: assert property (o_rd_valid == $past(i_bus.rd))
      else $error("read valid not one cycle after read");
   a_boot_addr_const: assert property (o_boot_addr == BOOT_ADDR)
      else $error("boot address changed");
   a_fixed_level: assert property (vec_q.req && vec_q.num < NUM_FIXED |-> vec_q.level == FIXED_LEVEL)
      else $error("fixed source at wrong level");
   a_unmasked_shown: assert property ($past(|lvl_found) && !$past(dis_q) |-> vec_q.req)
      else $error("permitted request not presented");
   a_disable_blocks: assert property ($past(dis_q) |-> !vec_q.req)
      else $error("request presented while disabled");
   a_snap_frozen: assert property (i_low_power |=> en_snap_q == $past(en_snap_q))
      else $error("wake enables changed during sleep");
   a_fast_slot1_addr: assert property (vec_q.fast && $past(fm_q[0][VEC_W-1:0]) != vec_q.num |->
      vec_q.addr == {$past(fvh_q[1]), $past(fvl_q[1])})
      else $error("fast slot 1 address wrong");
endmodule
`default_nettype wire

// *** sim/pic_core_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// Stand-in for the core and the system integration unit.
// It takes the boot address, sleeps on command and wakes on request.
module pic_core_model
(
   input  wire logic i_sys_clk,   // System clock
   input  wire logic i_rst,       // Reset, active high
   input  wire logic i_boot_en,   // Boot address is driven
   input  wire logic i_wake,      // Wake request
   input  wire logic i_sleep,     // Enter wait or stop
   output var  logic o_boot_ack,  // Boot address taken
   output var  logic o_low_power  // Core asleep
);
   logic [1:0] boot_cnt_q;

   // The core takes a few cycles before it fetches the boot address.
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
         boot_cnt_q <= 2'h0;
      else if (i_boot_en && !o_boot_ack)
         boot_cnt_q <= boot_cnt_q + 2'h1;
   end

   assign o_boot_ack = i_boot_en && (boot_cnt_q == 2'h3);

   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
         o_low_power <= 1'b0;
      else if (i_wake)
         o_low_power <= 1'b0;
      else if (i_sleep)
         o_low_power <= 1'b1;
   end
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
module testbench
   import pic_pkg::*;
;
   logic               clk = 1'b0;
   logic               rst = 1'b1;
   pic_bus_req_t       bus = '0;
   logic [DATA_W-1:0]  rdata;
   logic               rd_valid;
   logic [NUM_SRC-1:0] irq = '0;
   logic [1:0]         mask = 2'h0;
   logic               low_power;
   logic               boot_ack;
   logic               sleep = 1'b0;
   pic_vec_t           vec;
   logic               wake;
   logic               boot_en;
   logic [VADDR_W-1:0] boot_addr;
   int                 miscompares = 0;
   int                 cmp_count = 0;
   int                 cyc = 0;

   always #12.5 clk = ~clk;

   pic_top dut_u (.i_sys_clk(clk), .i_rst(rst), .i_bus(bus), .o_rdata(rdata), .o_rd_valid(rd_valid),
                  .i_irq(irq), .i_sr_mask(mask), .i_low_power(low_power), .i_boot_ack(boot_ack),
                  .o_vec(vec), .o_wake(wake), .o_boot_en(boot_en), .o_boot_addr(boot_addr));

   pic_core_model core_u (.i_sys_clk(clk), .i_rst(rst), .i_boot_en(boot_en), .i_wake(wake),
                          .i_sleep(sleep), .o_boot_ack(boot_ack), .o_low_power(low_power));

   ////////////////////////////////////////////////////////////////////////////
   task automatic results;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // A hang counts as a mismatch and closes the run.
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         miscompares++;
         results;
      end
   end

   task automatic cmp_bit(input string n, input logic e, input logic g);
      cmp_count++;
      if (e !== g)
      begin
         miscompares++;
         $display("[ERR] %s exp %b got %b", n, e, g);
      end
   endtask

   task automatic cmp_reg(input string n, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (e !== g)
      begin
         miscompares++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask

   task automatic cmp_vec(input string n, input pic_vec_t e, input pic_vec_t g);
      cmp_count++;
      if (e !== g)
      begin
         miscompares++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask

   function automatic pic_vec_t ev(input logic [1:0] l, input logic [6:0] n, input logic [15:0] b);
      ev = '{1'b1, 1'b0, l, n, {9'h0, b, n}};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk) #1 bus = '{1'b1, 1'b0, a, d};
      @(posedge clk) #1 bus = '0;
   endtask

   task automatic rd(input logic [4:0] a, input logic [15:0] e);
      @(posedge clk) #1 bus = '{1'b0, 1'b1, a, 16'h0};
      @(posedge clk) #1 bus = '0;
      cmp_bit("rd_valid", 1'b1, rd_valid);
      cmp_reg("rdata", e, rdata);
   endtask

   task automatic settle;
      repeat (2) @(posedge clk);
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      cmp_bit("boot_en", 1'b1, boot_en);
      cmp_reg("boot_lo", 16'h0, boot_addr[15:0]);
      cmp_reg("boot_hi", BOOT_ADDR[31:16], boot_addr[31:16]);
      for (int a = 0; a < 15; a++)
         rd(a[4:0], 16'h0);
      rd(OFS_CTRL, 16'h0);
      rd(5'h10, 16'h0);
      cmp_bit("boot_en", 1'b0, boot_en);
   endtask

   task automatic t_fields;
      wr(OFS_PRI0, 16'hffff);
      rd(OFS_PRI0, 16'hc3ff);
      wr(5'h01, 16'hffff);
      rd(5'h01, 16'hfcff);
      wr(5'h02, 16'hffff);
      rd(5'h02, 16'hf3ff);
      wr(OFS_PEND0, 16'hffff);
      rd(OFS_PEND0, 16'h0);
      wr(5'h10, 16'hffff);
      rd(5'h10, 16'h0);
      for (int a = 0; a < 3; a++)
         wr(a[4:0], 16'h0);
   endtask

   // Low-voltage source 13 and debug source 6 through every field code.
   task automatic t_levels;
      for (int c = 0; c < 4; c++)
      begin
         wr(OFS_PRI0, {c[1:0], 12'h0, c[1:0]});
         irq = 46'h2000;
         settle;
         if (c == 0)
            cmp_bit("lvi_off", 1'b0, vec.req);
         else
            cmp_vec("lvi", ev(c[1:0] - 2'h1, 7'd13, 16'h0), vec);
         irq = 46'h40;
         settle;
         if (c == 0)
            cmp_bit("dbg_off", 1'b0, vec.req);
         else
            cmp_vec("dbg", ev(c[1:0], 7'd6, 16'h0), vec);
      end
      irq = '0;
      wr(OFS_PRI0, 16'h0);
   endtask

   task automatic t_order;
      wr(5'h03, 16'h000a);
      irq[31:30] = 2'h3;
      settle;
      cmp_vec("same_lvl", ev(2'h1, 7'd30, 16'h0), vec);
      wr(5'h03, 16'h000e);
      settle;
      cmp_vec("higher_lvl", ev(2'h2, 7'd31, 16'h0), vec);
      irq[5:0] = 6'h21;
      settle;
      cmp_vec("fixed", ev(2'h3, 7'd0, 16'h0), vec);
      irq = '0;
   endtask

   task automatic t_mask;
      wr(5'h03, 16'h0002);
      irq[30] = 1'b1;
      for (int m = 0; m < 4; m++)
      begin
         mask = m[1:0];
         settle;
         cmp_bit("masked", m <= 1, vec.req);
      end
      mask = 2'h0;
   endtask

   task automatic t_fast;
      wr(OFS_VBA, 16'h1234);
      wr(OFS_FM0, 16'd30);
      wr(OFS_FVL0, 16'hbeef);
      wr(OFS_FVH0, 16'h00a5);
      wr(5'h03, 16'h0003);
      settle;
      cmp_vec("fast0", '{1'b1, 1'b1, 2'h2, 7'd30, 32'h00a5_beef}, vec);
      wr(5'h03, 16'h0002);
      settle;
      cmp_vec("normal", ev(2'h1, 7'd30, 16'h1234), vec);
      wr(OFS_FM0, 16'h0);
      wr(OFS_FM1, 16'd30);
      wr(OFS_FVL1, 16'h0246);
      wr(OFS_FVH1, 16'h0001);
      wr(5'h03, 16'h0003);
      settle;
      cmp_vec("fast1", '{1'b1, 1'b1, 2'h2, 7'd30, 32'h0001_0246}, vec);
      rd(OFS_CTRL, {1'b1, FAST_LEVEL, 7'd30, 1'b0, 5'h00});
      wr(OFS_CTRL, 16'h0020);
      settle;
      cmp_bit("disabled", 1'b0, vec.req);
      wr(OFS_CTRL, 16'h0000);
      irq = '0;
   endtask

   // Source 39 is enabled before sleep, source 40 only during it.
   task automatic t_wake;
      wr(5'h04, 16'h000c);
      @(posedge clk) #1 sleep = 1'b1;
      @(posedge clk) #1 sleep = 1'b0;
      wr(5'h04, 16'h003c);
      irq[40] = 1'b1;
      settle;
      cmp_bit("no_wake", 1'b0, wake);
      cmp_bit("asleep", 1'b1, low_power);
      irq[39] = 1'b1;
      @(posedge clk);
      #1;
      cmp_bit("wake", 1'b1, wake);
      repeat (2) @(posedge clk);
      #1;
      cmp_bit("woken", 1'b0, low_power);
      irq = '0;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (12) @(posedge clk);
      #1 rst = 1'b0;
      t_reset;
      t_fields;
      t_levels;
      t_order;
      t_mask;
      t_fast;
      t_wake;
      results;
   end
endmodule
`default_nettype wire
